// File: pfbm_pkg.sv
// Package for the host-side parallel flash bus controller.
// Assumes a 100 MHz aclk and an asynchronous NOR flash on the pins.
package pfbm_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ADDR_ACCESS_NS = 70;
	localparam int unsigned SLEEP_EXTRA_NS = 30;
	localparam int unsigned CE_ACCESS_NS = 70;
	localparam int unsigned WRITE_PULSE_NS = 40;
	localparam int unsigned RESET_PULSE_NS = 500;
	localparam int unsigned RESET_RECOVERY_NS = 50;
	localparam int unsigned ACCESS_CYC = (CE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RECOVER_CYC = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SYNC_CYC = 2;
	localparam int unsigned SLEEP_CYC =
		(ADDR_ACCESS_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;

	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_ADDR = 12'h004;
	localparam logic [11:0] REG_WDATA = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam logic [11:0] REG_RDATA = 12'h010;
	localparam logic [11:0] REG_CFG = 12'h014;

	localparam int unsigned CTRL_READ = 0;
	localparam int unsigned CTRL_WRITE = 1;
	localparam int unsigned CTRL_RESET = 2;
	localparam int unsigned CFG_WORD = 0;
	localparam int unsigned CFG_ACCEL = 1;
	localparam int unsigned CFG_PROTECT_N = 2;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_READY = 1;
	localparam int unsigned ST_ACCEL = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PFBM_IDLE = 3'b000,
		PFBM_READ = 3'b001,
		PFBM_WRITE = 3'b011,
		PFBM_HOLD = 3'b010,
		PFBM_RST = 3'b110,
		PFBM_RECOVER = 3'b111
	} pfbm_state_e;

	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] dq_out;
		logic [15:0] dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_n;
		logic byte_n;
		logic accel_hv;
		logic protect_n;
	} pfbm_pins_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} pfbm_cmd_s;
endpackage : pfbm_pkg

// File: pfbm_axil.sv
// AXI4-Lite register slave for the flash controller.
// Assumes one write and one read under way at a time.
module pfbm_axil
	import pfbm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wr_stb,
	output pfbm_pkg::pfbm_cmd_s wr_cmd,
	input wire logic [31:0] rd_status,
	input wire logic [31:0] rd_data,
	input wire logic [31:0] rd_addr,
	input wire logic [31:0] rd_wdata,
	input wire logic [31:0] rd_cfg
);
	import pfbm_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic wr_stb;
		logic awready;
		logic wready;
		logic arready;
	} pfbm_axil_s;

	pfbm_axil_s st_r, st_nxt;

	function automatic logic known(input logic [11:0] a);
		return a == REG_CTRL || a == REG_ADDR || a == REG_WDATA || a == REG_STATUS ||
			a == REG_RDATA || a == REG_CFG;
	endfunction : known

	always_comb begin
		st_nxt = st_r;
		st_nxt.wr_stb = 1'b0;
		if (s_awvalid && s_awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_wdata;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = known(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
			st_nxt.wr_stb = known(st_r.awaddr);
		end
		if (st_r.bvalid && s_bready)
			st_nxt.bvalid = 1'b0;
		if (s_arvalid && s_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_araddr)
				REG_STATUS: st_nxt.rdata = rd_status;
				REG_RDATA: st_nxt.rdata = rd_data;
				REG_ADDR: st_nxt.rdata = rd_addr;
				REG_WDATA: st_nxt.rdata = rd_wdata;
				REG_CFG: st_nxt.rdata = rd_cfg;
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end else if (st_r.rvalid && s_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		// Ready terms registered so every bus output leaves a flop
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Byte enables ignored: every register is written as a whole word
	assign s_awready = st_r.awready;
	assign s_wready = st_r.wready;
	assign s_bvalid = st_r.bvalid;
	assign s_bresp = st_r.bresp;
	assign s_arready = st_r.arready;
	assign s_rvalid = st_r.rvalid;
	assign s_rdata = st_r.rdata;
	assign s_rresp = st_r.rresp;
	assign wr_stb = st_r.wr_stb;
	assign wr_cmd = '{addr: {20'h0_0000, st_r.awaddr}, data: st_r.wdata};
endmodule : pfbm_axil

// File: pfbm_host.sv
// Host controller driving an asynchronous parallel NOR flash's pins.
// Assumes the flash pins are resolved by the bench; ready_busy_out is async.
module pfbm_host
	import pfbm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output pfbm_pkg::pfbm_pins_s pins,
	input wire logic [15:0] data_pins_in,
	input wire logic ready_busy_out
);
	import pfbm_pkg::*;

	typedef struct packed {
		pfbm_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [15:0] rdata;
		logic [15:0] dq_m;
		logic [15:0] dq_s;
		logic [2:0] cfg;
		logic rb_m;
		logic rb_s;
		logic busy;
		logic pend_rd;
		logic pend_wr;
		logic pend_rst;
		pfbm_pins_s pins;
	} pfbm_host_s;

	pfbm_host_s st_r, st_nxt;
	logic wr_stb;
	pfbm_cmd_s wr_cmd;
	logic [31:0] status_w;

	function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
		return CNT_W'(n);
	endfunction : cyc

	assign status_w = {29'h0000_0000, st_r.cfg[CFG_ACCEL], st_r.rb_s, st_r.busy};

	pfbm_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_stb(wr_stb),
		.wr_cmd(wr_cmd),
		.rd_status(status_w),
		.rd_data({16'h0000, st_r.rdata}),
		.rd_addr(st_r.addr),
		.rd_wdata(st_r.wdata),
		.rd_cfg({29'h0000_0000, st_r.cfg})
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rb_m = ready_busy_out;
		st_nxt.rb_s = st_r.rb_m;
		// Data pins pass two flops too; reads are held longer to cover them
		st_nxt.dq_m = data_pins_in;
		st_nxt.dq_s = st_r.dq_m;
		st_nxt.pins.byte_n = st_r.cfg[CFG_WORD];
		st_nxt.pins.accel_hv = st_r.cfg[CFG_ACCEL];
		st_nxt.pins.protect_n = st_r.cfg[CFG_PROTECT_N];
		st_nxt.busy = st_r.state != PFBM_IDLE;
		if (st_r.cnt != '0)
			st_nxt.cnt = st_r.cnt - cyc(1);
		unique case (st_r.state)
			PFBM_IDLE: begin
				st_nxt.pins.ce_n = 1'b1; // Standby between cycles
				st_nxt.pins.oe_n = 1'b1;
				st_nxt.pins.we_n = 1'b1;
				st_nxt.pins.dq_oe = '0;
				if (st_r.pend_rst || !st_r.pins.reset_n) begin
					st_nxt.pend_rst = 1'b0;
					st_nxt.pins.reset_n = 1'b0;
					st_nxt.cnt = cyc(RESET_CYC);
					st_nxt.state = PFBM_RST;
				end else if (st_r.pend_wr) begin
					// Software sequences unlock, short-program, erase and id cycles
					st_nxt.pend_wr = 1'b0;
					st_nxt.pins.addr = st_r.addr[20:0];
					st_nxt.pins.ce_n = 1'b0;
					st_nxt.pins.we_n = 1'b0;
					st_nxt.pins.dq_out = st_r.wdata[15:0];
					st_nxt.pins.dq_oe = st_r.cfg[CFG_WORD] ? 16'hFFFF : 16'h00FF;
					if (!st_r.cfg[CFG_WORD]) begin
						st_nxt.pins.dq_out[15] = st_r.addr[21];
						st_nxt.pins.dq_oe[15] = 1'b1;
					end
					st_nxt.cnt = cyc(WRITE_CYC);
					st_nxt.state = PFBM_WRITE;
				end else if (st_r.pend_rd) begin
					st_nxt.pend_rd = 1'b0;
					st_nxt.pins.addr = st_r.addr[20:0];
					st_nxt.pins.ce_n = 1'b0;
					st_nxt.pins.oe_n = 1'b0;
					st_nxt.pins.dq_oe = '0;
					if (!st_r.cfg[CFG_WORD]) begin
						st_nxt.pins.dq_out[15] = st_r.addr[21];
						st_nxt.pins.dq_oe[15] = 1'b1;
					end
					// Full select access from standby plus sync; SLEEP_CYC is not used, so sleep is not covered
					st_nxt.cnt = cyc(ACCESS_CYC + SYNC_CYC);
					st_nxt.state = PFBM_READ;
				end
			end
			PFBM_READ: begin
				if (st_r.cnt == '0) begin
					st_nxt.rdata = st_r.cfg[CFG_WORD] ? st_r.dq_s
						: {8'h00, st_r.dq_s[7:0]};
					st_nxt.pins.oe_n = 1'b1; // Float device before we drive
					st_nxt.pins.ce_n = 1'b1;
					st_nxt.state = PFBM_HOLD;
				end
			end
			PFBM_WRITE: begin
				if (st_r.cnt == '0) begin
					st_nxt.pins.we_n = 1'b1;
					st_nxt.pins.ce_n = 1'b1;
					st_nxt.state = PFBM_HOLD;
				end
			end
			PFBM_HOLD: begin
				st_nxt.pins.dq_oe = '0;
				st_nxt.state = PFBM_IDLE;
			end
			PFBM_RST: begin
				if (st_r.cnt == '0) begin
					st_nxt.pins.reset_n = 1'b1;
					st_nxt.cnt = cyc(RECOVER_CYC);
					st_nxt.state = PFBM_RECOVER;
				end
			end
			PFBM_RECOVER: begin
				// Also waits ready, so an aborted embedded reset completes
				if (st_r.cnt == '0 && st_r.rb_s)
					st_nxt.state = PFBM_IDLE;
			end
			default: st_nxt.state = PFBM_IDLE;
		endcase
		// Decoded last, so a new request wins over the clear of one in service
		if (wr_stb) begin
			unique case (wr_cmd.addr[11:0])
				REG_ADDR: st_nxt.addr = wr_cmd.data;
				REG_WDATA: st_nxt.wdata = wr_cmd.data;
				REG_CFG: st_nxt.cfg = wr_cmd.data[2:0];
				REG_CTRL: begin
					st_nxt.pend_rd = st_nxt.pend_rd | wr_cmd.data[CTRL_READ];
					st_nxt.pend_wr = st_nxt.pend_wr | wr_cmd.data[CTRL_WRITE];
					st_nxt.pend_rst = st_nxt.pend_rst | wr_cmd.data[CTRL_RESET];
				end
				default: ;
			endcase
		end
	end

	// Bank and sector layouts are decoded by software through the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.state <= PFBM_IDLE;
			st_r.pins.ce_n <= 1'b1;
			st_r.pins.oe_n <= 1'b1;
			st_r.pins.we_n <= 1'b1;
			st_r.pins.reset_n <= 1'b0;
			st_r.cfg <= 3'b101;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins = st_r.pins;
endmodule : pfbm_host

// File: pfbm_flash_model.sv
// Behavioural flash on the far side of the host pins.
// Assumes the pins struct of pfbm_host; resolves the data pins itself.
module pfbm_flash_model (
	input wire pfbm_pkg::pfbm_pins_s pins,
	output logic [15:0] data_pins_in,
	output logic ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import pfbm_pkg::*;
	// Flat word array: every bank, sector and id word answers alike
	logic [15:0] mem [int];
	logic [15:0] q = 16'hffff;
	logic armed = 1'b0;
	logic drv;
	int wa;
	initial ready_busy_out = 1'b1;
	// Array read with no command; floats when deselected, disabled or reset
	assign drv = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_n;
	// Output stays latched while the address is stable
	always @(pins.addr or drv) begin
		if (drv) q = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
	end
	// Released lines show the inverse, never the last value; byte mode floats the top
	assign data_pins_in = (pins.dq_oe & pins.dq_out) |
		(~pins.dq_oe & (!drv ? ~q : pins.byte_n ? q : {~q[15:8], q[7:0]}));
	// Address on the falling write edge, data on the rising one
	always @(negedge pins.we_n) begin
		armed = !pins.ce_n && pins.oe_n && pins.reset_n;
		wa = pins.addr;
	end
	// Runs on when deselected; high voltage programs faster
	always @(posedge pins.we_n) begin
		if (armed) begin
			mem[wa] = pins.dq_out;
			ready_busy_out = 1'b0;
			ready_busy_out <= #(pins.accel_hv ? 100 : 300) 1'b1;
		end
	end
	// Reset aborts, busy until internal reset ends
	always @(negedge pins.reset_n) begin
		armed = 1'b0;
		ready_busy_out = 1'b0;
		ready_busy_out <= #200 1'b1;
	end
endmodule : pfbm_flash_model

// File: pfbm_host_chk.sv
// Pin sequencing checks for the flash host.
// Bound to pfbm_host; sees aclk, aresetn and pins only.
module pfbm_host_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire pfbm_pkg::pfbm_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import pfbm_pkg::*;
	logic [7:0] low_r;
	// Saturates so a long pulse never wraps under the floor
	always_ff @(posedge aclk) begin
		low_r <= (!aresetn || pins.reset_n) ? 8'h00 : low_r + {7'h00, low_r != 8'hff};
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_cmd_strobes: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
		else $error("write strobe outside a command cycle");
	a_write_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n [*4])
		else $error("write pulse too short");
	a_byte_float: assert property (!pins.byte_n |-> pins.dq_oe[14:8] == 7'h00)
		else $error("middle data pins driven in byte mode");
	a_read_nodrive: assert property (!pins.oe_n |-> pins.dq_oe[14:0] == 15'h0000)
		else $error("host drives data during a read");
	a_read_access: assert property ($fell(pins.oe_n) |-> (!pins.oe_n && !pins.ce_n) [*7])
		else $error("read access cut short");
	a_reset_width: assert property ($rose(pins.reset_n) |-> low_r >= RESET_CYC - 1)
		else $error("flash reset pulse too short");
	a_reset_quiet: assert property (!pins.reset_n |-> pins.ce_n && pins.we_n)
		else $error("access during flash reset");
	a_reset_recover: assert property ($rose(pins.reset_n) |-> pins.ce_n [*5])
		else $error("access before reset recovery");
endmodule : pfbm_host_chk

bind pfbm_host pfbm_host_chk u_chk (.aclk(aclk), .aresetn(aresetn), .pins(pins));

// File: pfbm_host_tb.sv
// Bench: AXI4-Lite master, reference store, flash model.
// Assumes pfbm_host with its checker bound beside it.
module pfbm_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pfbm_pkg::*;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ready_busy_out;
	logic [11:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rs;
	logic [15:0] data_pins_in;
	pfbm_pins_s pins;
	int fail_count, total_checks, a;
	int exp_mem [int];
	pfbm_host dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.pins(pins),
		.data_pins_in(data_pins_in),
		.ready_busy_out(ready_busy_out)
	);
	pfbm_flash_model flash (
		.pins(pins),
		.data_pins_in(data_pins_in),
		.ready_busy_out(ready_busy_out)
	);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo(input logic hit);
		if (!hit) begin
			fail_count++;
			$display("unexpected at %0t: no answer", $time);
			report_and_stop();
		end
	endtask : tmo
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		int n;
		logic aw_t, w_t, done;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		s_awaddr <= ad;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		// Sampled mid-cycle, so the edge that ends the handshake is never raced
		do begin
			@(negedge aclk);
			n++;
			aw_t = s_awready;
			w_t = s_wready;
			done = s_bvalid;
			rs = s_bresp;
			@(posedge aclk);
			if (aw_t) s_awvalid <= 1'b0;
			if (w_t) s_wvalid <= 1'b0;
		end while (!done && n < 200);
		s_bready <= 1'b0;
		tmo(done);
	endtask : wr
	task automatic rdr(input logic [11:0] ad);
		int n;
		logic ar_t, done;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		s_araddr <= ad;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
			ar_t = s_arready;
			done = s_rvalid;
			rd = s_rdata;
			rs = s_rresp;
			@(posedge aclk);
			if (ar_t) s_arvalid <= 1'b0;
		end while (!done && n < 200);
		s_rready <= 1'b0;
		tmo(done);
	endtask : rdr
	// Two idle polls in a row, so a stale synced ready cannot pass
	task automatic idle;
		int n;
		int ok;
		n = 0;
		ok = 0;
		do begin
			rdr(REG_STATUS);
			ok = (rd[1:0] === 2'b10) ? ok + 1 : 0;
			n++;
		end while (ok < 2 && n < 200);
		tmo(ok >= 2);
	endtask : idle
	task automatic fop(input int ad, input int d, input logic [31:0] cmd);
		wr(REG_ADDR, ad);
		wr(REG_WDATA, d);
		wr(REG_CTRL, cmd);
		idle();
	endtask : fop
	initial begin
		aresetn = 1'b0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		s_awaddr = 12'h000;
		s_araddr = 12'h000;
		s_wdata = 32'h0000_0000;
		s_wstrb = 4'hf;
		void'($urandom(32'he185_6e17));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		idle();
		rdr(REG_STATUS);
		chk(rd[2:0], 3'h2);
		rdr(REG_CFG);
		chk(rd[2:0], 3'h5);
		wr(REG_CFG, 32'h0000_0001);
		rdr(REG_CFG);
		chk({rd[2:0], pins.protect_n}, 4'h2);
		wr(REG_CFG, 32'h0000_0005);
		repeat (5) begin
			a = $urandom_range(0, 32'h001f_ffff);
			exp_mem[a] = $urandom_range(0, 32'h0000_ffff);
			fop(a, exp_mem[a], 32'h0000_0002);
		end
		wr(REG_CFG, 32'h0000_0007);
		rdr(REG_STATUS);
		chk(rd[2], 1'h1);
		chk(pins.accel_hv, 1'b1);
		exp_mem[32'h0000_1234] = 32'h0000_a5c3;
		fop(32'h0000_1234, 32'h0000_a5c3, 32'h0000_0002);
		wr(REG_CFG, 32'h0000_0005);
		rdr(REG_STATUS);
		chk(rd[2], 1'h0);
		chk(pins.accel_hv, 1'b0);
		wr(REG_CFG, 32'h0000_0004);
		fop(32'h0020_0077, 32'h0000_005a, 32'h0000_0002);
		fop(32'h0020_0077, 0, 32'h0000_0001);
		rdr(REG_RDATA);
		chk({pins.byte_n, rd[15:0]}, 17'h0_005a);
		wr(REG_CFG, 32'h0000_0005);
		exp_mem[32'h0000_0456] = 32'h0000_0f0f;
		fop(32'h0000_0456, 32'h0000_0f0f, 32'h0000_0006);
		fop(32'h0010_0001, 0, 32'h0000_0001);
		rdr(REG_RDATA);
		chk(rd[15:0], 16'hffff);
		foreach (exp_mem[k]) begin
			fop(k, 0, 32'h0000_0001);
			rdr(REG_RDATA);
			chk(rd[15:0], exp_mem[k]);
		end
		wr(12'h0fc, 32'h0000_0001);
		chk(rs, RESP_SLVERR);
		rdr(12'h0fc);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0000_0000);
		report_and_stop();
	end
endmodule : pfbm_host_tb
